// >>> comparator_model.sv
// Comparator stage stand-in that feeds the load switch timer
`timescale 1ns/1ps

module comparator_model (
  input  wire vin_low,    // Supply below trip level
  input  wire load_heavy, // Load above primary limit
  input  wire die_hot,    // Die above shutdown point
  output wire uv_ind,     // Undervoltage indication
  output wire oc_ind,     // Current limiting indication
  output wire ot_ind      // Over-temperature indication
);
  // ==========
  // Comparators follow the analog conditions
  assign uv_ind = vin_low;
  assign oc_ind = load_heavy;
  assign ot_ind = die_hot;
endmodule // comparator_model

// >>> interval_timer.v
// Parameterised down-counting interval timer with restart and clear
`timescale 1ns/1ps

module interval_timer #(
  parameter WIDTH = 24
) (
  input  wire             clk,     // System clock
  input  wire             reset,   // Synchronous reset, active high
  input  wire             start,   // Load the interval and begin counting
  input  wire             clear,   // Abort the count
  input  wire [WIDTH-1:0] length,  // Interval in cycles
  output reg              running, // Counting in progress
  output wire             done     // One-cycle pulse at expiry
);

  reg [WIDTH-1:0] count_q;

  // Expiry when the last cycle of the interval is counted
  assign done = running && (count_q == {{(WIDTH-1){1'b0}}, 1'b1}) && !start && !clear;

  // ============================================================
  // Counter
  // ============================================================
  always @(posedge clk)
  begin
    if (reset || clear)
    begin
      running <= 1'b0;
      count_q <= {WIDTH{1'b0}};
    end
    else if (start)
    begin
      running <= 1'b1;
      count_q <= length;
    end
    else if (running)
    begin
      count_q <= count_q - {{(WIDTH-1){1'b0}}, 1'b1};
      if (count_q == {{(WIDTH-1){1'b0}}, 1'b1})
        running <= 1'b0;
    end
  end

endmodule // interval_timer

// >>> load_switch_map.vh
// Timing constants and reset values for the load switch timer block
`ifndef LOAD_SWITCH_MAP_VH
`define LOAD_SWITCH_MAP_VH

// ============================================================
// Timebase
// ============================================================
`define CLK_PERIOD_NS      10
`define BLANK_TIME_MS      32
`define RETRY_TIME_MS      128
`define SURGE_TIME_MS      128
`define LOCKOUT_TIME_MS    128
`define NS_PER_MS          1000000

// Cycle counts at the 10 ns timebase, sized for the 24-bit timers
`define BLANK_CYCLES       24'h30d400
`define RETRY_CYCLES       24'hc35000
`define SURGE_CYCLES       24'hc35000
`define LOCKOUT_CYCLES     24'hc35000

// ============================================================
// Reset values
// ============================================================
`define SWITCH_ON_RST      1'b0
`define SECONDARY_SEL_RST  1'b0
`define UV_SYNC_RST        2'h3

`endif

// >>> load_switch_uvlo_surge_timer.v
// Undervoltage guard and surge-allowance timing for a load switch
`timescale 1ns/1ps
`include "load_switch_map.vh"

//
// Behaviour
// - The load is cut only after undervoltage has held without a break for the whole 32 ms blanking time.
// - After an undervoltage cut the switch stays off for a 128 ms wait before power returns.
// - If undervoltage persists after power returns, the load runs one 32 ms blanking time and is cut again, cyclically.
// - Once undervoltage is gone the switch returns to and stays in normal on operation.
// - The blanking count clears whenever undervoltage deasserts, and the indication gets no hysteresis.
// - The undervoltage guard and surge timer are independent, so a long undervoltage cuts the load mid-surge.
// - At first turn-on the switch stays off while the sense input is at or below its threshold.
// - At the start of an overcurrent the secondary limit is selected for 128 ms, then the primary limit.
// - Leaving current limiting starts a 128 ms lock-out in which no new surge above the primary limit can begin.
// - Over-temperature ends any surge and turns the output off, and after cooling overcurrent stays at primary.
module load_switch_uvlo_surge_timer #(
  parameter [23:0] BLANK_CYCLES   = `BLANK_CYCLES,   // 32 ms blanking
  parameter [23:0] RETRY_CYCLES   = `RETRY_CYCLES,   // 128 ms retry wait
  parameter [23:0] SURGE_CYCLES   = `SURGE_CYCLES,   // 128 ms surge allowance
  parameter [23:0] LOCKOUT_CYCLES = `LOCKOUT_CYCLES  // 128 ms lock-out
) (
  input  wire clk,                     // 100 MHz timebase
  input  wire reset,                   // Synchronous reset, active high
  input  wire undervoltage_sense,      // High while sense pin is at or below threshold
  input  wire overcurrent,             // High while output is in current limiting
  input  wire over_temperature,        // High while die is too hot
  output reg  switch_on,               // Pass device enable
  output reg  secondary_current_limit  // High selects the higher limit
);

  // ============================================================
  // Input synchronisers
  // ============================================================
  reg [1:0] uv_sync_q;
  reg [1:0] oc_sync_q;
  reg [1:0] ot_sync_q;
  wire      uv;
  wire      oc;
  wire      ot;

  // Two flops per comparator input
  always @(posedge clk)
  begin
    if (reset)
    begin
      uv_sync_q <= `UV_SYNC_RST; // Assume low supply until seen otherwise
      oc_sync_q <= 2'h0;
      ot_sync_q <= 2'h0;
    end
    else
    begin
      uv_sync_q <= {uv_sync_q[0], undervoltage_sense};
      oc_sync_q <= {oc_sync_q[0], overcurrent};
      ot_sync_q <= {ot_sync_q[0], over_temperature};
    end
  end

  assign uv = uv_sync_q[1];
  assign oc = oc_sync_q[1];
  assign ot = ot_sync_q[1];

  // ============================================================
  // Undervoltage guard state machine
  // ============================================================
  localparam [3:0] ST_HOLD  = 4'h1; // After reset, waiting for a good supply
  localparam [3:0] ST_IDLE  = 4'h2; // Sense above threshold
  localparam [3:0] ST_BLANK = 4'h4; // Undervoltage seen, blanking, load still on
  localparam [3:0] ST_RETRY = 4'h8; // Load cut, waiting to retry

  reg  [3:0] uv_state_q;
  reg  [3:0] uv_state_d;
  wire       blank_done;
  wire       retry_done;
  reg        blank_start;
  reg        blank_clear;
  reg        retry_start;

  // Blanking interval counter
  interval_timer #(.WIDTH(24)) blank_timer (
    .clk     (clk),
    .reset   (reset),
    .start   (blank_start),
    .clear   (blank_clear),
    .length  (BLANK_CYCLES),
    .running (),
    .done    (blank_done)
  );

  // Retry wait counter
  interval_timer #(.WIDTH(24)) retry_timer (
    .clk     (clk),
    .reset   (reset),
    .start   (retry_start),
    .clear   (1'b0),
    .length  (RETRY_CYCLES),
    .running (),
    .done    (retry_done)
  );

  // Next state and timer controls
  always @*
  begin
    uv_state_d  = uv_state_q;
    blank_start = 1'b0;
    blank_clear = 1'b0;
    retry_start = 1'b0;
    case (uv_state_q)
      ST_HOLD:
      begin
        // First turn-on waits for the sense input to rise above threshold
        if (!uv)
          uv_state_d = ST_IDLE;
      end
      ST_IDLE:
      begin
        if (uv)
        begin
          blank_start = 1'b1;
          uv_state_d  = ST_BLANK;
        end
      end
      ST_BLANK:
      begin
        if (!uv)
        begin
          blank_clear = 1'b1;
          uv_state_d  = ST_IDLE;
        end
        else if (blank_done)
        begin
          retry_start = 1'b1;
          uv_state_d  = ST_RETRY;
        end
      end
      ST_RETRY:
      begin
        if (retry_done)
        begin
          // Power returns; a still-low supply re-enters blanking
          if (uv)
          begin
            blank_start = 1'b1;
            uv_state_d  = ST_BLANK;
          end
          else
            uv_state_d = ST_IDLE;
        end
      end
      default:
        uv_state_d = ST_HOLD;
    endcase
  end

  // State register
  always @(posedge clk)
  begin
    if (reset)
      uv_state_q <= ST_HOLD;
    else
      uv_state_q <= uv_state_d;
  end

  // ============================================================
  // Surge allowance and lock-out
  // ============================================================
  reg  oc_prev_q;
  reg  ot_block_q;
  wire surge_done;
  wire surge_running;
  wire lock_running;
  wire surge_start;
  wire lock_start;

  // Surge only on a fresh overcurrent, outside lock-out and heat block
  assign surge_start = oc && !oc_prev_q && !lock_running && !ot && !ot_block_q;
  // Lock-out begins as current limiting ends
  assign lock_start  = !oc && oc_prev_q;

  // Surge window counter, cut short by over-temperature
  interval_timer #(.WIDTH(24)) surge_timer (
    .clk     (clk),
    .reset   (reset),
    .start   (surge_start),
    .clear   (ot),
    .length  (SURGE_CYCLES),
    .running (surge_running),
    .done    (surge_done)
  );

  // Lock-out counter
  interval_timer #(.WIDTH(24)) lock_timer (
    .clk     (clk),
    .reset   (reset),
    .start   (lock_start),
    .clear   (1'b0),
    .length  (LOCKOUT_CYCLES),
    .running (lock_running),
    .done    ()
  );

  // Overcurrent history and thermal block
  always @(posedge clk)
  begin
    if (reset)
    begin
      oc_prev_q  <= 1'b0;
      ot_block_q <= 1'b0;
    end
    else
    begin
      oc_prev_q <= oc;
      if (ot)
        ot_block_q <= 1'b1;
      else if (!oc)
        ot_block_q <= 1'b0;        // Load gone, surge allowed again
    end
  end

  // ============================================================
  // Outputs
  // ============================================================
  always @(posedge clk)
  begin
    if (reset)
    begin
      switch_on               <= `SWITCH_ON_RST;
      secondary_current_limit <= `SECONDARY_SEL_RST;
    end
    else
    begin
      // On in normal running and through blanking; off while holding, retrying or hot
      switch_on <= ((uv_state_d == ST_IDLE) || (uv_state_d == ST_BLANK)) && !ot;
      // Higher limit only inside the surge window
      secondary_current_limit <= (surge_start || (surge_running && !surge_done)) && !ot;
    end
  end

endmodule // load_switch_uvlo_surge_timer

// >>> load_switch_uvlo_surge_timer_properties.sv
// Port checks for the load switch timer
`timescale 1ns/1ps

module ls_timer_checker #(
  parameter [23:0] BLANK_CYCLES = 24'd20,
  parameter [23:0] SURGE_CYCLES = 24'd40,
  parameter [23:0] RETRY_CYCLES = 24'd40
) (
  input wire clk,                     // Timebase
  input wire reset,                   // Sync reset
  input wire undervoltage_sense,      // Sense low
  input wire overcurrent,             // Limiting
  input wire over_temperature,        // Hot die
  input wire switch_on,               // Pass enable
  input wire secondary_current_limit  // Higher limit
);
  reg [23:0] sec_run_q;
  reg [23:0] quiet_q;
  reg [23:0] uv_run_q;
  reg        run_from_on_q;
  reg        hold_q;
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  // ==========
  // Run length of the surge and of quiet inputs
  always @(posedge clk)
  begin
    if (reset || !secondary_current_limit)
      sec_run_q <= 24'h0;
    else
      sec_run_q <= sec_run_q + 24'h1;
    if (reset || undervoltage_sense || over_temperature)
      quiet_q <= 24'h0;
    else if (quiet_q < RETRY_CYCLES + 24'd8)
      quiet_q <= quiet_q + 24'h1;
    if (reset || !undervoltage_sense)
      uv_run_q <= 24'h0;
    else if (uv_run_q != 24'hffffff)
      uv_run_q <= uv_run_q + 24'h1;
    if (reset)
      run_from_on_q <= 1'b0;
    else if (!undervoltage_sense)
      run_from_on_q <= switch_on;
    if (reset)
      hold_q <= 1'b1;
    else if (!undervoltage_sense)
      hold_q <= 1'b0;
  end
  // Undervoltage from a running load has lasted blanking plus pipeline
  sequence uv_run_end;
    run_from_on_q && (uv_run_q == BLANK_CYCLES + 24'd3);
  endsequence
  sequence hot_long;
    over_temperature [*5];
  endsequence
  // ==========
  // Assertions
  reset_off_a: assert property (disable iff (1'b0) reset |=> !switch_on && !secondary_current_limit)
    else $error("output active after reset");
  uv_cut_a: assert property (uv_run_end |-> !switch_on)
    else $error("load not cut after blanking");
  retry_hold_a: assert property (uv_run_end |=> !switch_on [*8])
    else $error("switch back on during retry wait");
  hot_cut_a: assert property (hot_long |=> !switch_on)
    else $error("switch on while hot");
  hot_sec_a: assert property (hot_long |=> !secondary_current_limit)
    else $error("surge while hot");
  surge_cause_a: assert property ($rose(secondary_current_limit) |->
    ($past(overcurrent, 2) || $past(overcurrent, 3) || $past(overcurrent, 4)))
    else $error("surge without overcurrent");
  surge_bound_a: assert property (sec_run_q <= SURGE_CYCLES + 24'd1)
    else $error("surge too long");
  hold_start_a: assert property (hold_q |-> !switch_on)
    else $error("switch on before supply was good");
  quiet_on_a: assert property (quiet_q >= RETRY_CYCLES + 24'd8 |-> switch_on)
    else $error("switch off with quiet inputs");
endmodule // ls_timer_checker

bind load_switch_uvlo_surge_timer ls_timer_checker #(
  .BLANK_CYCLES(BLANK_CYCLES),
  .SURGE_CYCLES(SURGE_CYCLES),
  .RETRY_CYCLES(RETRY_CYCLES)
) chk_i (
  .clk(clk),
  .reset(reset),
  .undervoltage_sense(undervoltage_sense),
  .overcurrent(overcurrent),
  .over_temperature(over_temperature),
  .switch_on(switch_on),
  .secondary_current_limit(secondary_current_limit)
);

// >>> load_switch_uvlo_surge_timer_tb.sv
// Self-checking bench for the load switch timer
`timescale 1ns/1ps

module load_switch_uvlo_surge_timer_tb;
  reg        clk = 1'b0;
  reg        reset = 1'b1;
  reg        vin_low = 1'b0;
  reg        load_heavy = 1'b0;
  reg        die_hot = 1'b0;
  wire       uv, oc, ot, switch_on, sec;
  integer    err_total = 0;
  integer    checks = 0;
  integer    cyc = 0;
  integer    i;
  reg [15:0] rows [0:27];
  // ==========
  // Clock, far side and design
  always #5 clk = ~clk;
  comparator_model pm (.vin_low(vin_low), .load_heavy(load_heavy), .die_hot(die_hot),
    .uv_ind(uv), .oc_ind(oc), .ot_ind(ot));
  load_switch_uvlo_surge_timer #(.BLANK_CYCLES(24'd20), .RETRY_CYCLES(24'd40),
    .SURGE_CYCLES(24'd40), .LOCKOUT_CYCLES(24'd40)) DUT (.clk(clk), .reset(reset),
    .undervoltage_sense(uv), .overcurrent(oc), .over_temperature(ot),
    .switch_on(switch_on), .secondary_current_limit(sec));
  // ==========
  // Shared tasks
  task chk(input logic seen, input logic exp);
  begin
    checks = checks + 1;
    if (seen !== exp)
    begin
      err_total = err_total + 1;
      $display("mismatch at %0t: output differs", $time);
    end
  end
  endtask
  task step(input integer n);
  begin
    repeat (n) @(posedge clk);
    #1;
  end
  endtask
  task report_and_stop;
  begin
    if (err_total == 0 && checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  end
  endtask
  // Hang guard
  always @(posedge clk)
  begin
    cyc = cyc + 1;
    if (cyc > 1000)
    begin
      err_total = err_total + 1;
      report_and_stop;
    end
  end
  // ==========
  // Rows: wait, check, uv, load, hot, on, secondary
  initial
  begin
    rows = '{16'h0a30, 16'h0220, 16'h0122, 16'h0a32, 16'h0522, 16'h0f32, 16'h0732,
      16'h0130, 16'h2730, 16'h0132, 16'h1332, 16'h0130, 16'h1420, 16'h1320,
      16'h0122, 16'h022a, 16'h012b, 16'h272b, 16'h012a, 16'h0522, 16'h052a,
      16'h2d22, 16'h033b, 16'h1439, 16'h062c, 16'h0728, 16'h1e2a, 16'h3222};
    step(20);
    chk(switch_on, 1'b0);
    chk(sec, 1'b0);
    reset = 1'b0;
    for (i = 0; i < 28; i = i + 1)
    begin
      vin_low = rows[i][4];
      load_heavy = rows[i][3];
      die_hot = rows[i][2];
      step(rows[i][15:8]);
      if (rows[i][5])
      begin
        chk(switch_on, rows[i][1]);
        chk(sec, rows[i][0]);
      end
    end
    // Second reset in mid-run
    load_heavy = 1'b1;
    step(5);
    reset = 1'b1;
    step(3);
    chk(switch_on, 1'b0);
    chk(sec, 1'b0);
    reset = 1'b0;
    step(2);
    chk(switch_on, 1'b0);
    chk(sec, 1'b0);
    step(6);
    chk(switch_on, 1'b1);
    chk(sec, 1'b1);
    report_and_stop;
  end
endmodule // load_switch_uvlo_surge_timer_tb
